/* hdl/frm_byte_reg.sv */
// One byte control register with per-bit write mask.
// Assumes one-cycle write strobes from the control port.
`timescale 1ns/100ps
`default_nettype none
module frm_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic mclk,        // core clock
  input wire logic rst_n,       // sync reset
  input wire logic wr,          // write strobe for this byte
  input wire logic [7:0] wdata, // write data
  output logic [7:0] q          // stored value
);
  logic [7:0] q_reg;
  logic [7:0] q_next;

  // Read-only bits keep their reset value
  assign q_next = wr ? ((wdata & WMASK) | (RST_VAL & ~WMASK)) : q_reg;
  assign q = q_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

/* hdl/frm_fault_ctrl.sv */
// Fault report, mask and latch controller of the amplifier core.
// Assumes detector levels and control port strobes synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module frm_fault_ctrl (
  input wire logic mclk,             // core clock, 250 MHz
  input wire logic rst_n,            // sync reset, active low
  input wire logic [7:0] reg_addr,   // register offset
  input wire logic [7:0] reg_wdata,  // write data
  input wire logic reg_wr,           // write strobe, one cycle
  input wire logic reg_rd,           // read strobe, one cycle
  input wire logic overtemp_shutdown,// overtemp shutdown detector
  input wire logic overtemp_warning, // overtemp warning detector
  input wire logic core_low,         // core supply undervoltage
  input wire logic core_high,        // core supply overvoltage
  input wire logic clk_fault,        // clock fault detector
  input wire logic clk_detect,       // live clock detection status
  input wire logic pwr_low,          // power supply undervoltage
  input wire logic pwr_high,         // power supply overvoltage
  input wire logic [1:0] dc_fault,   // per-channel DC fault
  input wire logic [1:0] oc_fault,   // per-channel overcurrent
  input wire logic [1:0] cbc_fault,  // per-channel limit fault
  input wire logic [1:0] cbc_warn,   // per-channel limit warning
  output logic [7:0] reg_rdata,      // read data, valid after reg_rd
  output logic reg_rvalid,           // read data strobe
  output logic fault_n,              // fault report, active low
  output logic warn_n,               // warning report, active low
  output logic out_hiz,              // output stage tri-state
  output logic clk_detect_status,    // held or live detect status
  output logic current_limit_enable, // to limiter
  output logic current_limit_warning_enable, // to limiter
  output logic current_limit_fault_enable,   // to limiter
  output logic overtemp_auto_recovery_enable // to shutdown logic
);

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_rmask = reg_addr == frm_pkg::REPORT_MASK_OFS;
  wire hit_lmask = reg_addr == frm_pkg::LATCH_MASK_OFS;
  wire hit_misc = reg_addr == frm_pkg::MISC_OFS;
  wire hit_cl = reg_addr == frm_pkg::CUR_LIMIT_OFS;
  wire hit_clr = reg_addr == frm_pkg::CLEAR_OFS;
  wire hit_chan = reg_addr == frm_pkg::CHAN_STAT_OFS;
  wire hit_glob1 = reg_addr == frm_pkg::GLOB1_STAT_OFS;
  wire hit_glob2 = reg_addr == frm_pkg::GLOB2_STAT_OFS;
  wire hit_warn = reg_addr == frm_pkg::WARN_STAT_OFS;

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] report_mask;
  logic [7:0] latch_mask;
  logic [7:0] misc_ctrl;
  logic [7:0] cl_ctrl;
  logic [7:0] clr_store;

  // Position 3 is read-only zero
  frm_byte_reg #(
    .RST_VAL(frm_pkg::REPORT_MASK_RST),
    .WMASK(frm_pkg::REPORT_MASK_WMASK)
  ) u_rmask (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(reg_wr && hit_rmask),
    .wdata(reg_wdata),
    .q(report_mask)
  );

  // Latch enables come out of reset set
  frm_byte_reg #(
    .RST_VAL(frm_pkg::LATCH_MASK_RST),
    .WMASK(frm_pkg::ALL_WMASK)
  ) u_lmask (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(reg_wr && hit_lmask),
    .wdata(reg_wdata),
    .q(latch_mask)
  );

  frm_byte_reg #(
    .RST_VAL(frm_pkg::MISC_RST),
    .WMASK(frm_pkg::ALL_WMASK)
  ) u_misc (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(reg_wr && hit_misc),
    .wdata(reg_wdata),
    .q(misc_ctrl)
  );

  frm_byte_reg #(
    .RST_VAL(frm_pkg::CUR_LIMIT_RST),
    .WMASK(frm_pkg::ALL_WMASK)
  ) u_cl (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(reg_wr && hit_cl),
    .wdata(reg_wdata),
    .q(cl_ctrl)
  );

  // Only the reserved low bits are stored; bit 7 is a command
  frm_byte_reg #(
    .RST_VAL(frm_pkg::CLEAR_RST),
    .WMASK(frm_pkg::CLEAR_WMASK)
  ) u_clr (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(reg_wr && hit_clr),
    .wdata(reg_wdata),
    .q(clr_store)
  );

  // ****************************************
  // Field views
  // ****************************************
  wire overtemp_shutdown_report_mask = report_mask[frm_pkg::MSK_OVERTEMP_SHUTDOWN];
  wire core_supply_low_report_mask = report_mask[frm_pkg::MSK_CORE_LOW];
  wire core_supply_high_report_mask = report_mask[frm_pkg::MSK_CORE_HIGH];
  wire clock_fault_report_mask = report_mask[frm_pkg::MSK_CLK];
  wire power_supply_voltage_report_mask = report_mask[frm_pkg::MSK_PWR];
  wire dc_offset_fault_report_mask = report_mask[frm_pkg::MSK_DC];
  wire overcurrent_report_mask = report_mask[frm_pkg::MSK_OC];
  wire overtemp_warning_report_mask = latch_mask[frm_pkg::MSK_OTW];
  wire current_limit_warning_report_mask =
    latch_mask[frm_pkg::MSK_CBC_WARN];
  wire current_limit_fault_report_mask =
    latch_mask[frm_pkg::MSK_CBC_FAULT];
  wire clock_detect_status_hold = misc_ctrl[frm_pkg::MISC_DET_HOLD];
  wire auto_rec = misc_ctrl[frm_pkg::MISC_AUTO_REC];
  wire cl_on = cl_ctrl[frm_pkg::CL_EN];

  // Command bit pulses for one cycle on a write of 1
  wire fault_clr = reg_wr && hit_clr && reg_wdata[frm_pkg::CLR_BIT];

  // ****************************************
  // Sticky indications
  // ****************************************
  logic [frm_pkg::NUM_IND-1:0] src_vec;
  logic [frm_pkg::NUM_IND-1:0] lat_vec;
  logic [frm_pkg::NUM_IND-1:0] ind;

  // Limit sources pass only while the limiter and their own enable are set
  wire [1:0] cbcf_q = cbc_fault & {2{cl_on && cl_ctrl[frm_pkg::CL_FAULT_EN]}};
  wire [1:0] cbcw_q = cbc_warn & {2{cl_on && cl_ctrl[frm_pkg::CL_WARN_EN]}};

  assign src_vec[frm_pkg::IX_OVERTEMP_SHUTDOWN] = overtemp_shutdown;
  assign src_vec[frm_pkg::IX_CLK] = clk_fault;
  assign src_vec[frm_pkg::IX_CBCF1] = cbcf_q[0];
  assign src_vec[frm_pkg::IX_CBCF2] = cbcf_q[1];
  assign src_vec[frm_pkg::IX_CBCW1] = cbcw_q[0];
  assign src_vec[frm_pkg::IX_CBCW2] = cbcw_q[1];
  assign src_vec[frm_pkg::IX_OTW] = overtemp_warning;
  assign src_vec[frm_pkg::IX_DC1] = dc_fault[0];
  assign src_vec[frm_pkg::IX_DC2] = dc_fault[1];
  assign src_vec[frm_pkg::IX_OC1] = oc_fault[0];
  assign src_vec[frm_pkg::IX_OC2] = oc_fault[1];
  assign src_vec[frm_pkg::IX_PUV] = pwr_low;
  assign src_vec[frm_pkg::IX_POV] = pwr_high;

  // Auto recovery overrides the shutdown latch
  assign lat_vec[frm_pkg::IX_OVERTEMP_SHUTDOWN] =
    latch_mask[frm_pkg::LAT_OVERTEMP_SHUTDOWN] && !auto_rec;
  assign lat_vec[frm_pkg::IX_CLK] = latch_mask[frm_pkg::LAT_CLK];
  assign lat_vec[frm_pkg::IX_CBCF1] = latch_mask[frm_pkg::LAT_CBC_FAULT];
  assign lat_vec[frm_pkg::IX_CBCF2] = latch_mask[frm_pkg::LAT_CBC_FAULT];
  assign lat_vec[frm_pkg::IX_CBCW1] = latch_mask[frm_pkg::LAT_CBC_WARN];
  assign lat_vec[frm_pkg::IX_CBCW2] = latch_mask[frm_pkg::LAT_CBC_WARN];
  assign lat_vec[frm_pkg::IX_OTW] = latch_mask[frm_pkg::LAT_OTW];
  // DC and overcurrent always hold until cleared
  assign lat_vec[frm_pkg::IX_DC1] = 1'b1;
  assign lat_vec[frm_pkg::IX_DC2] = 1'b1;
  assign lat_vec[frm_pkg::IX_OC1] = 1'b1;
  assign lat_vec[frm_pkg::IX_OC2] = 1'b1;
  // Supply faults recover on their own
  assign lat_vec[frm_pkg::IX_PUV] = 1'b0;
  assign lat_vec[frm_pkg::IX_POV] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < frm_pkg::NUM_IND; gi = gi + 1) begin : g_ind
      // Latch enables steer each indication
      frm_sticky u_cell (
        .mclk(mclk),
        .rst_n(rst_n),
        .src(src_vec[gi]),
        .latch_en(lat_vec[gi]),
        .clr(fault_clr),
        .ind(ind[gi])
      );
    end
  endgenerate

  // ****************************************
  // Report gating
  // ****************************************
  wire rep_overtemp_shutdown = ind[frm_pkg::IX_OVERTEMP_SHUTDOWN] &&
    !overtemp_shutdown_report_mask;
  wire rep_core = (core_low && !core_supply_low_report_mask) ||
    (core_high && !core_supply_high_report_mask);
  wire rep_clk = ind[frm_pkg::IX_CLK] &&
    !clock_fault_report_mask;
  wire rep_pwr = (ind[frm_pkg::IX_PUV] || ind[frm_pkg::IX_POV]) &&
    !power_supply_voltage_report_mask;
  wire rep_dc = (ind[frm_pkg::IX_DC1] || ind[frm_pkg::IX_DC2]) &&
    !dc_offset_fault_report_mask;
  wire rep_oc = (ind[frm_pkg::IX_OC1] || ind[frm_pkg::IX_OC2]) &&
    !overcurrent_report_mask;
  wire rep_cbcf = (ind[frm_pkg::IX_CBCF1] || ind[frm_pkg::IX_CBCF2]) &&
    !current_limit_fault_report_mask;
  wire rep_cbcw = (ind[frm_pkg::IX_CBCW1] || ind[frm_pkg::IX_CBCW2]) &&
    !current_limit_warning_report_mask;
  wire rep_otw = ind[frm_pkg::IX_OTW] &&
    !overtemp_warning_report_mask;

  // Any unmasked live or held fault pulls the pin
  wire fault_any = rep_overtemp_shutdown || rep_core || rep_clk || rep_pwr ||
    rep_dc || rep_oc || rep_cbcf;
  wire warn_any = rep_cbcw || rep_otw;

  // Masks affect the report only, never the output stage
  wire hiz_any = ind[frm_pkg::IX_OVERTEMP_SHUTDOWN] || ind[frm_pkg::IX_CLK] ||
    ind[frm_pkg::IX_DC1] || ind[frm_pkg::IX_DC2] ||
    ind[frm_pkg::IX_OC1] || ind[frm_pkg::IX_OC2] ||
    ind[frm_pkg::IX_PUV] || ind[frm_pkg::IX_POV];

  // ****************************************
  // Clock detection status
  // ****************************************
  logic det_reg;
  // Held mode keeps a 1 until cleared; clear loses to a new detect
  wire det_next = clock_detect_status_hold ?
    (clk_detect || (det_reg && !fault_clr)) : clk_detect;

  // ****************************************
  // Read path
  // ****************************************
  wire [7:0] chan_view = {4'h0, ind[frm_pkg::IX_DC1],
    ind[frm_pkg::IX_DC2], ind[frm_pkg::IX_OC1], ind[frm_pkg::IX_OC2]};
  wire [7:0] glob1_view = {5'h00, ind[frm_pkg::IX_CLK],
    ind[frm_pkg::IX_POV], ind[frm_pkg::IX_PUV]};
  wire [7:0] glob2_view = {5'h00, ind[frm_pkg::IX_CBCF2],
    ind[frm_pkg::IX_CBCF1], ind[frm_pkg::IX_OVERTEMP_SHUTDOWN]};
  wire [7:0] warn_view = {2'h0, ind[frm_pkg::IX_CBCW1],
    ind[frm_pkg::IX_CBCW2], 3'h0, ind[frm_pkg::IX_OTW]};

  // Clear command bit reads back as zero
  wire [7:0] rd_mux =
    hit_rmask ? report_mask :
    hit_lmask ? latch_mask :
    hit_misc ? misc_ctrl :
    hit_cl ? cl_ctrl :
    hit_clr ? clr_store :
    hit_chan ? chan_view :
    hit_glob1 ? glob1_view :
    hit_glob2 ? glob2_view :
    hit_warn ? warn_view : 8'h00;

  // ****************************************
  // Output flops
  // ****************************************
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic fault_n_reg;
  logic warn_n_reg;
  logic hiz_reg;
  logic [2:0] cl_out_reg;
  logic auto_rec_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      fault_n_reg <= 1'b1;
      warn_n_reg <= 1'b1;
      hiz_reg <= 1'b0;
      det_reg <= 1'b0;
      cl_out_reg <= 3'h0;
      auto_rec_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : rdata_reg;
      rvalid_reg <= reg_rd;
      fault_n_reg <= !fault_any;
      warn_n_reg <= !warn_any;
      hiz_reg <= hiz_any;
      det_reg <= det_next;
      // Enables steer the limiter
      cl_out_reg <= {cl_on, cl_on && cl_ctrl[frm_pkg::CL_WARN_EN],
        cl_on && cl_ctrl[frm_pkg::CL_FAULT_EN]};
      auto_rec_reg <= auto_rec;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign fault_n = fault_n_reg;
  assign warn_n = warn_n_reg;
  assign out_hiz = hiz_reg;
  assign clk_detect_status = det_reg;
  assign current_limit_enable = cl_out_reg[2];
  assign current_limit_warning_enable = cl_out_reg[1];
  assign current_limit_fault_enable = cl_out_reg[0];
  assign overtemp_auto_recovery_enable = auto_rec_reg;

endmodule
`default_nettype wire

/* hdl/frm_pkg.sv */
// Constants for the fault report, mask and latch controller.
// Assumes one core clock and byte registers on the core's control port.
package frm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CHAN_STAT_OFS = 8'h70;
  localparam logic [7:0] GLOB1_STAT_OFS = 8'h71;
  localparam logic [7:0] GLOB2_STAT_OFS = 8'h72;
  localparam logic [7:0] WARN_STAT_OFS = 8'h73;
  localparam logic [7:0] REPORT_MASK_OFS = 8'h74;
  localparam logic [7:0] LATCH_MASK_OFS = 8'h75;
  localparam logic [7:0] MISC_OFS = 8'h76;
  localparam logic [7:0] CUR_LIMIT_OFS = 8'h77;
  localparam logic [7:0] CLEAR_OFS = 8'h78;

  // ****************************************
  // Reset values and writable bits
  // ****************************************
  localparam logic [7:0] REPORT_MASK_RST = 8'h00;
  localparam logic [7:0] REPORT_MASK_WMASK = 8'hF7;
  localparam logic [7:0] LATCH_MASK_RST = 8'hF8;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] CUR_LIMIT_RST = 8'h00;
  localparam logic [7:0] CLEAR_RST = 8'h00;
  localparam logic [7:0] CLEAR_WMASK = 8'h7F;
  localparam logic [7:0] ALL_WMASK = 8'hFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MSK_OVERTEMP_SHUTDOWN = 7;
  localparam int MSK_CORE_LOW = 6;
  localparam int MSK_CORE_HIGH = 5;
  localparam int MSK_CLK = 4;
  localparam int MSK_PWR = 2;
  localparam int MSK_DC = 1;
  localparam int MSK_OC = 0;
  localparam int LAT_CBC_FAULT = 7;
  localparam int LAT_CBC_WARN = 6;
  localparam int LAT_CLK = 5;
  localparam int LAT_OVERTEMP_SHUTDOWN = 4;
  localparam int LAT_OTW = 3;
  localparam int MSK_OTW = 2;
  localparam int MSK_CBC_WARN = 1;
  localparam int MSK_CBC_FAULT = 0;
  localparam int MISC_DET_HOLD = 7;
  localparam int MISC_AUTO_REC = 4;
  localparam int CL_EN = 2;
  localparam int CL_WARN_EN = 1;
  localparam int CL_FAULT_EN = 0;
  localparam int CLR_BIT = 7;

  // ****************************************
  // Sticky indication slots
  // ****************************************
  localparam int IX_OVERTEMP_SHUTDOWN = 0;
  localparam int IX_CLK = 1;
  localparam int IX_CBCF1 = 2;
  localparam int IX_CBCF2 = 3;
  localparam int IX_CBCW1 = 4;
  localparam int IX_CBCW2 = 5;
  localparam int IX_OTW = 6;
  localparam int IX_DC1 = 7;
  localparam int IX_DC2 = 8;
  localparam int IX_OC1 = 9;
  localparam int IX_OC2 = 10;
  localparam int IX_PUV = 11;
  localparam int IX_POV = 12;
  localparam int NUM_IND = 13;

endpackage

/* hdl/frm_sticky.sv */
// One fault or warning indication with optional latching.
// Assumes src is a level synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module frm_sticky (
  input wire logic mclk,     // core clock
  input wire logic rst_n,    // sync reset
  input wire logic src,      // live detector level
  input wire logic latch_en, // hold after source drops
  input wire logic clr,      // one-cycle clear pulse
  output logic ind           // live or held indication
);
  logic held_reg;
  logic held_next;

  // Set wins over a clear arriving in the same cycle
  assign held_next = (src && latch_en) ? 1'b1 : (clr ? 1'b0 : held_reg);
  assign ind = src | held_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      held_reg <= 1'b0;
    end else begin
      held_reg <= held_next;
    end
  end
endmodule
`default_nettype wire

/* sim/frm_fault_ctrl_asserts.sv */
// Port-level assertions for the fault report, mask and latch controller.
// Assumes binding to frm_fault_ctrl; control bytes are mirrored from writes.
`timescale 1ns/100ps
`default_nettype none
module frm_fault_ctrl_chk (
  input wire logic mclk, // core clock
  input wire logic rst_n, // sync reset
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic overtemp_shutdown, // detector
  input wire logic overtemp_warning, // detector
  input wire logic core_low, // detector
  input wire logic core_high, // detector
  input wire logic clk_fault, // detector
  input wire logic pwr_low, // detector
  input wire logic pwr_high, // detector
  input wire logic [1:0] dc_fault, // detector
  input wire logic [1:0] oc_fault, // detector
  input wire logic [1:0] cbc_fault, // detector
  input wire logic [1:0] cbc_warn, // detector
  input wire logic [7:0] reg_rdata, // read data
  input wire logic fault_n, // fault report
  input wire logic warn_n, // warning report
  input wire logic out_hiz, // stage off
  input wire logic current_limit_enable, // enable
  input wire logic current_limit_warning_enable, // enable
  input wire logic current_limit_fault_enable, // enable
  input wire logic overtemp_auto_recovery_enable // enable
);
  logic [7:0] m74, m75, m76, m77;
  logic quiet, wr_clr;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  assign quiet = !(overtemp_shutdown | overtemp_warning | core_low
    | core_high | clk_fault | pwr_low | pwr_high | (|dc_fault)
    | (|oc_fault) | (|cbc_fault) | (|cbc_warn));
  assign wr_clr = reg_wr && reg_addr == 8'h78 && reg_wdata[7];
  // Mirror of the control bytes, as the checker cannot see inside
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      m74 <= 8'h00;
      m75 <= 8'hF8;
      m76 <= 8'h00;
      m77 <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h74) m74 <= reg_wdata & 8'hF7;
      if (reg_addr == 8'h75) m75 <= reg_wdata;
      if (reg_addr == 8'h76) m76 <= reg_wdata;
      if (reg_addr == 8'h77) m77 <= reg_wdata;
    end
  end
  // ****
  // Assertions
  // ****
  chk_mask_bit3_zero: assert property (
    reg_rd && reg_addr == 8'h74 |=> reg_rdata[3] == 1'b0)
    else $error("report mask bit 3 read as one");
  chk_clear_bit_zero: assert property (
    reg_rd && reg_addr == 8'h78 |=> reg_rdata[7] == 1'b0)
    else $error("clear bit read back as one");
  chk_dc_reported: assert property (
    (|dc_fault) && !m74[1] && !reg_wr |-> ##[1:2] !fault_n)
    else $error("unmasked dc fault not reported");
  chk_overtemp_shutdown_reported: assert property (
    overtemp_shutdown && !m74[7] && !reg_wr |-> ##[1:2] !fault_n)
    else $error("unmasked shutdown not reported");
  chk_dc_held: assert property (
    $past(rst_n) && $fell(|dc_fault) && !reg_wr |=> out_hiz)
    else $error("dc fault not held on output stage");
  chk_clear_release: assert property (
    wr_clr && quiet ##1 quiet |=> fault_n && warn_n && !out_hiz)
    else $error("clear did not release held faults");
  chk_limit_enables: assert property (
    reg_wr && reg_addr == 8'h77 ##1 !reg_wr |=> current_limit_enable
    == m77[2] && current_limit_warning_enable == (m77[2] & m77[1])
    && current_limit_fault_enable == (m77[2] & m77[0]))
    else $error("limit enables differ from written byte");
  chk_auto_recovery: assert property (
    reg_wr && reg_addr == 8'h76 ##1 !reg_wr
    |=> overtemp_auto_recovery_enable == m76[4])
    else $error("auto recovery enable differs from bit 4");
  chk_warn_masked: assert property (
    m75[2] && m75[1] && $past(m75[2] && m75[1]) |-> warn_n)
    else $error("warning reported while masked");
  chk_fault_masked: assert property (
    {m74, m75[0]} == 9'h1EF && $past({m74, m75[0]}) == 9'h1EF |-> fault_n)
    else $error("fault reported while all masked");
endmodule
bind frm_fault_ctrl frm_fault_ctrl_chk u_chk (.*);
`default_nettype wire

/* sim/tb_frm_fault_ctrl.sv */
// Self-checking bench for the fault report, mask and latch controller.
// Assumes the checker binds itself in; one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module tb_frm_fault_ctrl;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [15:0] s = 16'h0000;
  logic [15:0] h = 16'h0000;
  logic [7:0] m74 = 8'h00;
  logic [7:0] m75 = 8'hF8;
  logic [7:0] m76 = 8'h00;
  logic [7:0] m77 = 8'h00;
  logic [7:0] rdata;
  wire [7:0] outs;
  logic rvalid;
  integer failures = 0;
  integer n_tests = 0;
  integer seed = 31;
  integer cyc = 0;
  integer i;
  always #2 mclk = ~mclk;
  frm_fault_ctrl u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .overtemp_shutdown(s[0]),
    .overtemp_warning(s[1]), .core_low(s[2]), .core_high(s[3]),
    .clk_fault(s[4]), .clk_detect(s[5]), .pwr_low(s[6]), .pwr_high(s[7]),
    .dc_fault(s[9:8]), .oc_fault(s[11:10]), .cbc_fault(s[13:12]),
    .cbc_warn(s[15:14]), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .fault_n(outs[7]), .warn_n(outs[6]), .out_hiz(outs[5]),
    .clk_detect_status(outs[4]), .current_limit_enable(outs[3]),
    .current_limit_warning_enable(outs[2]),
    .current_limit_fault_enable(outs[1]),
    .overtemp_auto_recovery_enable(outs[0])
  );
  // ****
  // Reference model
  // ****
  function automatic logic [15:0] lat();
    lat = {{2{m75[6]}}, {2{m75[7]}}, 4'hF, 2'b00, m76[7], m75[5],
      2'b00, m75[3], m75[4] & ~m76[4]};
  endfunction
  // Status byte layout per offset, from live-or-held sources
  function automatic logic [7:0] stat(input logic [7:0] a,
    input logic [15:0] v);
    case (a)
      8'h70: stat = {4'h0, v[8], v[9], v[10], v[11]};
      8'h71: stat = {5'h00, v[4], v[7], v[6]};
      8'h72: stat = {5'h00, v[13], v[12], v[0]};
      default: stat = {2'h0, v[14], v[15], 3'h0, v[1]};
    endcase
  endfunction
  function automatic logic [15:0] gsrc();
    gsrc = s & {{2{m77[2] & m77[1]}}, {2{m77[2] & m77[0]}}, 12'hFFF};
  endfunction
  function automatic logic [7:0] expect_out(input logic [15:0] v);
    logic f, w;
    f = (v[0] & ~m74[7]) | (v[2] & ~m74[6]) | (v[3] & ~m74[5])
      | (v[4] & ~m74[4]) | ((|v[7:6]) & ~m74[2]) | ((|v[9:8]) & ~m74[1])
      | ((|v[11:10]) & ~m74[0]) | ((|v[13:12]) & ~m75[0]);
    w = (v[1] & ~m75[2]) | ((|v[15:14]) & ~m75[1]);
    expect_out = {~f, ~w, v[0] | v[4] | (|v[11:6]), v[5], m77[2],
      m77[2] & m77[1], m77[2] & m77[0], m76[4]};
  endfunction
  // Set wins over a clear in the same cycle
  always @(posedge mclk)
    if (!rst_n)
      h <= 16'h0000;
    else
      h <= (h & ~{16{wr && addr == 8'h78 && wd[7]}}) | (gsrc() & lat());
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures++;
      wrap_up();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic check(input string nm, input logic [7:0] e,
    input logic [7:0] v);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge mclk);
    wr <= 1'b0;
    if (a == 8'h74) m74 <= d & 8'hF7;
    if (a == 8'h75) m75 <= d;
    if (a == 8'h76) m76 <= d;
    if (a == 8'h77) m77 <= d;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check("rvalid", 8'h01, {7'h00, rvalid});
    check("rdata", e, rdata);
  endtask
  task automatic put(input logic [15:0] v);
    @(posedge mclk);
    s <= v;
  endtask
  task automatic stats();
    for (int k = 0; k < 4; k++)
      rreg(8'(8'h70 + k), stat(8'(8'h70 + k), gsrc() | h));
  endtask
  task automatic look();
    repeat (3) @(posedge mclk);
    #1;
    check("outputs", expect_out(gsrc() | h), outs);
  endtask
  // One pass: clear, program the bytes, raise, clear, drop, clear
  task automatic round(input logic [31:0] mk, input logic [15:0] v);
    put(16'h0000);
    wreg(8'h78, 8'h80);
    wreg(8'h74, mk[31:24]);
    wreg(8'h75, mk[23:16]);
    wreg(8'h76, mk[15:8]);
    wreg(8'h77, mk[7:0]);
    rreg(8'h74, mk[31:24] & 8'hF7);
    rreg(8'h75, mk[23:16]);
    put(v);
    look();
    stats();
    wreg(8'h78, 8'h80);
    look();
    put(16'h0000);
    look();
    stats();
    wreg(8'h78, 8'h80);
    look();
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(8'h74, 8'h00);
    rreg(8'h75, 8'hF8);
    rreg(8'h76, 8'h00);
    rreg(8'h77, 8'h00);
    rreg(8'h78, 8'h00);
    look();
    wreg(8'h78, 8'hFF);
    rreg(8'h78, 8'h7F);
    // Unmapped place: write ignored, reads zero
    wreg(8'h79, 8'hFF);
    rreg(8'h79, 8'h00);
    round(32'hFFFF8007, 16'hFFFF);
    // Latches on, so auto recovery must beat the shutdown latch
    round(32'h00F81007, 16'hFFFF);
    for (i = 0; i < 16; i++)
      round(32'h00F88007, 16'h0001 << i);
    for (i = 0; i < 60; i++)
      round(32'($random(seed)), 16'($random(seed) & $random(seed)));
    wrap_up();
  end
endmodule
`default_nettype wire
